/* iocl_pkg.sv */
package iocl_pkg;

  // register byte addresses
  localparam logic [7:0]  IOCL_CTRL_OFS     = 8'h00;
  localparam logic [7:0]  IOCL_STATUS_OFS   = 8'h04;
  localparam logic [7:0]  IOCL_CONFIG_OFS   = 8'h08;

  // control register fields
  localparam int          CTRL_OUT_SEL_LSB  = 0;
  localparam int          CTRL_OUT_INIT     = 2;
  localparam int          CTRL_IN_INIT      = 3;
  localparam int          CTRL_OUT_CLK_INV  = 4;
  localparam int          CTRL_IN_CLK_INV   = 5;
  localparam int          CTRL_TRI_INV      = 6;
  localparam int          CTRL_IN_DELAY     = 7;
  localparam int          CTRL_TAP1_LSB     = 8;
  localparam int          CTRL_TAP2_LSB     = 10;
  localparam int          CTRL_PULL_LSB     = 12;
  localparam int          CTRL_WIDTH        = 14;
  localparam logic [13:0] CTRL_RESET        = 14'h0080;

  // status register fields
  localparam int          STAT_PAD          = 0;
  localparam int          STAT_TAP1         = 1;
  localparam int          STAT_TAP2         = 2;
  localparam int          STAT_OUT_Q        = 3;
  localparam int          STAT_IN_MASTER    = 4;
  localparam int          STAT_IN_SLAVE     = 5;
  localparam int          STAT_USER         = 6;
  localparam int          STAT_OE           = 7;

  // config register fields
  localparam int          CFG_DONE          = 0;
  localparam logic        CFG_DONE_RESET    = 1'b0;

  // field encodings
  localparam logic [1:0]  OUT_SEL_DIRECT    = 2'h0;
  localparam logic [1:0]  OUT_SEL_INVERT    = 2'h1;
  localparam logic [1:0]  OUT_SEL_FLOP      = 2'h2;
  localparam logic [1:0]  TAP_SEL_PAD       = 2'h0;
  localparam logic [1:0]  TAP_SEL_MASTER    = 2'h1;
  localparam logic [1:0]  TAP_SEL_SLAVE     = 2'h2;
  localparam logic [1:0]  PULL_NONE         = 2'h0;
  localparam logic [1:0]  PULL_UP           = 2'h1;
  localparam logic [1:0]  PULL_DOWN         = 2'h2;

  // input path timing, in pclk cycles
  localparam int          DELAY_STAGES      = 2;

  typedef enum logic [1:0] {
    IOCL_ST_CONFIG  = 2'b00,
    IOCL_ST_STARTUP = 2'b01,
    IOCL_ST_USER    = 2'b11
  } iocl_state_t;

endpackage

/* iocl_ms_flop.sv */
module iocl_ms_flop
  import iocl_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // data and user clock, polarity already applied
  input  wire logic d,
  input  wire logic clk_eff,
  // initial state control
  input  wire logic init_val,
  input  wire logic hold_init,
  // latch outputs and clock edge pulse
  output logic      master_q,
  output logic      slave_q,
  output logic      edge_pulse
);

  logic prev_reg;
  logic master_reg;
  logic slave_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= clk_eff;
    end
  end

  assign edge_pulse = clk_eff & ~prev_reg;

  // master is open while the user clock is inactive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_reg <= 1'b0;
    end else if (hold_init) begin
      master_reg <= init_val;
    end else if (!clk_eff) begin
      master_reg <= d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_reg <= 1'b0;
    end else if (hold_init) begin
      slave_reg <= init_val;
    end else if (edge_pulse) begin
      slave_reg <= master_reg;
    end
  end

  assign master_q = master_reg;
  assign slave_q  = slave_reg;

endmodule

/* iocl_in_path.sv */
module iocl_in_path
  import iocl_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pad side
  input  wire logic pad_in,
  // core side
  output logic      pad_fast,
  output logic      pad_slow
);

  logic                    sync1_reg;
  logic                    sync2_reg;
  logic [DELAY_STAGES-1:0] dly_reg;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_reg <= '0;
    end else begin
      dly_reg[0] <= sync2_reg;
      for (int i = 1; i < DELAY_STAGES; i++) begin
        dly_reg[i] <= dly_reg[i-1];
      end
    end
  end

  assign pad_fast = sync2_reg;
  assign pad_slow = dly_reg[DELAY_STAGES-1];

endmodule

/* iocl_top.sv */
// Contract
// - output buffer driven by core output, its inverse, or output flop value.
// - each flop takes its configured set or clear state when configuration completes.
// - global set/reset after configuration forces every flop to its initial state.
// - each flop clock edge is selectable per cell by an invert bit.
// - three-state enable polarity is selectable per cell.
// - pad input feeds internal logic directly and the input flop data.
// - optional delay before the input flop, on by default, removable.
// - two input taps, each from pad data, master latch or slave latch.
// - pin pull is selectable: weak up, weak down or none.
// - during configuration every pin is weakly pulled high.
module iocl_top
  import iocl_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // core logic side
  input  wire logic        core_out,
  input  wire logic        core_tristate,
  input  wire logic        out_clk,
  input  wire logic        in_clk,
  input  wire logic        global_sr,
  output logic             input_tap_one,
  output logic             input_tap_two,
  // pad side
  input  wire logic        pad_in,
  output logic             pad_out,
  output logic             pad_oe,
  output logic             pull_up_en,
  output logic             pull_down_en
);

  iocl_state_t           state_reg;
  iocl_state_t           state_next;
  logic [CTRL_WIDTH-1:0] ctrl_reg;
  logic                  cfg_done_reg;
  logic [31:0]           prdata_reg;
  logic [31:0]           rd_mux;
  logic                  acc;
  logic                  wr_en;
  logic                  mapped;
  logic                  hold_init;
  logic [1:0]            out_sel;
  logic [1:0]            tap1_sel;
  logic [1:0]            tap2_sel;
  logic [1:0]            pull_sel;
  logic                  out_init;
  logic                  in_init;
  logic                  out_clk_eff;
  logic                  in_clk_eff;
  logic                  tri_inv;
  logic                  in_delay_en;
  logic                  pad_fast;
  logic                  pad_slow;
  logic                  in_d;
  logic                  out_slave;
  logic                  out_edge;
  logic                  in_master;
  logic                  in_slave;
  logic                  in_edge;
  logic                  out_mux;
  logic                  tap_one_reg;
  logic                  tap_two_reg;
  logic                  pad_out_reg;
  logic                  pad_oe_reg;
  logic                  pull_up_reg;
  logic                  pull_down_reg;

  // field decode
  assign out_sel     = ctrl_reg[CTRL_OUT_SEL_LSB+:2];
  assign tap1_sel    = ctrl_reg[CTRL_TAP1_LSB+:2];
  assign tap2_sel    = ctrl_reg[CTRL_TAP2_LSB+:2];
  assign pull_sel    = ctrl_reg[CTRL_PULL_LSB+:2];
  assign out_init    = ctrl_reg[CTRL_OUT_INIT];
  assign in_init     = ctrl_reg[CTRL_IN_INIT];
  assign tri_inv     = ctrl_reg[CTRL_TRI_INV];
  assign in_delay_en = ctrl_reg[CTRL_IN_DELAY];

  // apb decode; zero wait states, read data staged in the setup cycle
  assign acc     = psel & penable;
  assign wr_en   = acc & pwrite;
  assign mapped  = (paddr == IOCL_CTRL_OFS) || (paddr == IOCL_STATUS_OFS) || (paddr == IOCL_CONFIG_OFS);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_en && paddr == IOCL_CTRL_OFS) begin
      if (pstrb[0]) begin
        ctrl_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        ctrl_reg[CTRL_WIDTH-1:8] <= pwdata[CTRL_WIDTH-1:8];
      end
    end
  end

  // clearing done drops the cell back into configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done_reg <= CFG_DONE_RESET;
    end else if (wr_en && paddr == IOCL_CONFIG_OFS && pstrb[0]) begin
      cfg_done_reg <= pwdata[CFG_DONE];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      IOCL_CTRL_OFS: begin
        rd_mux[CTRL_WIDTH-1:0] = ctrl_reg;
      end
      IOCL_STATUS_OFS: begin
        rd_mux[STAT_PAD]       = pad_fast;
        rd_mux[STAT_TAP1]      = tap_one_reg;
        rd_mux[STAT_TAP2]      = tap_two_reg;
        rd_mux[STAT_OUT_Q]     = out_slave;
        rd_mux[STAT_IN_MASTER] = in_master;
        rd_mux[STAT_IN_SLAVE]  = in_slave;
        rd_mux[STAT_USER]      = (state_reg == IOCL_ST_USER);
        rd_mux[STAT_OE]        = pad_oe_reg;
      end
      IOCL_CONFIG_OFS: begin
        rd_mux[CFG_DONE] = cfg_done_reg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  // configuration sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IOCL_ST_CONFIG: begin
        if (cfg_done_reg) begin
          state_next = IOCL_ST_STARTUP;
        end
      end
      IOCL_ST_STARTUP: begin
        state_next = cfg_done_reg ? IOCL_ST_USER : IOCL_ST_CONFIG;
      end
      IOCL_ST_USER: begin
        if (!cfg_done_reg) begin
          state_next = IOCL_ST_CONFIG;
        end
      end
      default: begin
        state_next = IOCL_ST_CONFIG;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= IOCL_ST_CONFIG;
    end else begin
      state_reg <= state_next;
    end
  end

  // flops sit at their init value until user mode and under global set/reset
  assign hold_init = (state_reg != IOCL_ST_USER) || global_sr;

  // user clocks come from core logic on pclk, so no synchroniser
  assign out_clk_eff = out_clk ^ ctrl_reg[CTRL_OUT_CLK_INV];
  assign in_clk_eff  = in_clk ^ ctrl_reg[CTRL_IN_CLK_INV];

  iocl_ms_flop u_out_flop (
    .pclk       (pclk),
    .presetn    (presetn),
    .d          (core_out),
    .clk_eff    (out_clk_eff),
    .init_val   (out_init),
    .hold_init  (hold_init),
    .master_q   (),
    .slave_q    (out_slave),
    .edge_pulse (out_edge)
  );

  iocl_in_path u_in_path (
    .pclk     (pclk),
    .presetn  (presetn),
    .pad_in   (pad_in),
    .pad_fast (pad_fast),
    .pad_slow (pad_slow)
  );

  // the delayed path trades setup time for hold margin
  assign in_d = in_delay_en ? pad_slow : pad_fast;

  iocl_ms_flop u_in_flop (
    .pclk       (pclk),
    .presetn    (presetn),
    .d          (in_d),
    .clk_eff    (in_clk_eff),
    .init_val   (in_init),
    .hold_init  (hold_init),
    .master_q   (in_master),
    .slave_q    (in_slave),
    .edge_pulse (in_edge)
  );

  // output path
  always_comb begin
    case (out_sel)
      OUT_SEL_DIRECT: out_mux = core_out;
      OUT_SEL_INVERT: out_mux = ~core_out;
      OUT_SEL_FLOP:   out_mux = out_slave;
      default:        out_mux = core_out;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out_reg <= 1'b0;
    end else begin
      pad_out_reg <= out_mux;
    end
  end

  // buffer floats throughout configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_oe_reg <= 1'b0;
    end else begin
      pad_oe_reg <= (state_reg == IOCL_ST_USER) && (core_tristate == tri_inv);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_up_reg   <= 1'b1;
      pull_down_reg <= 1'b0;
    end else if (state_reg != IOCL_ST_USER) begin
      pull_up_reg   <= 1'b1;
      pull_down_reg <= 1'b0;
    end else begin
      pull_up_reg   <= (pull_sel == PULL_UP);
      pull_down_reg <= (pull_sel == PULL_DOWN);
    end
  end

  // input taps
  function automatic logic tap_pick(input logic [1:0] sel, input logic raw, input logic m, input logic s);
    logic r;
    case (sel)
      TAP_SEL_MASTER: r = m;
      TAP_SEL_SLAVE:  r = s;
      default:        r = raw;
    endcase
    return r;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_one_reg <= 1'b0;
      tap_two_reg <= 1'b0;
    end else begin
      tap_one_reg <= tap_pick(tap1_sel, pad_fast, in_master, in_slave);
      tap_two_reg <= tap_pick(tap2_sel, pad_fast, in_master, in_slave);
    end
  end

  assign input_tap_one = tap_one_reg;
  assign input_tap_two = tap_two_reg;
  assign pad_out       = pad_out_reg;
  assign pad_oe        = pad_oe_reg;
  assign pull_up_en    = pull_up_reg;
  assign pull_down_en  = pull_down_reg;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cfg_complete;
    (state_reg == IOCL_ST_CONFIG) && cfg_done_reg ##1 (state_reg == IOCL_ST_STARTUP) && cfg_done_reg;
  endsequence

  sequence s_user_active;
    (state_reg == IOCL_ST_USER) && !global_sr;
  endsequence

  out_direct_a: assert property ((out_sel == OUT_SEL_DIRECT) |=> pad_out_reg == $past(core_out))
    else $error("direct output path wrong");
  out_invert_a: assert property ((out_sel == OUT_SEL_INVERT) |=> pad_out_reg != $past(core_out))
    else $error("inverted output path wrong");
  out_flop_path_a: assert property ((out_sel == OUT_SEL_FLOP) |=> pad_out_reg == $past(out_slave))
    else $error("registered output path wrong");
  init_on_done_a: assert property (s_cfg_complete |=> (state_reg == IOCL_ST_USER)
      && out_slave == $past(out_init) && in_slave == $past(in_init))
    else $error("flops not at initial state after configuration");
  gsr_force_a: assert property (global_sr |=> out_slave == $past(out_init)
      && in_master == $past(in_init) && in_slave == $past(in_init))
    else $error("global set reset did not force initial state");
  in_edge_sel_a: assert property (s_user_active and (in_clk ^ ctrl_reg[CTRL_IN_CLK_INV]) && !$past(in_clk_eff)
      |=> in_slave == $past(in_master))
    else $error("input flop missed its selected edge");
  oe_polarity_a: assert property ((state_reg == IOCL_ST_USER)
      |=> pad_oe_reg == ($past(core_tristate) == $past(tri_inv)))
    else $error("three state polarity wrong");
  oe_cfg_float_a: assert property ((state_reg != IOCL_ST_USER) |=> !pad_oe_reg)
    else $error("output driven during configuration");
  raw_feed_a: assert property (s_user_active and !in_clk_eff && !in_delay_en
      |=> in_master == $past(pad_fast))
    else $error("input flop not fed from pad");
  delay_line_a: assert property (pad_slow == $past(pad_fast, 2))
    else $error("input delay length wrong");
  delay_feed_a: assert property (s_user_active and !in_clk_eff && in_delay_en
      |=> in_master == $past(pad_slow))
    else $error("delayed input not used");
  tap_one_src_a: assert property ((tap1_sel == TAP_SEL_PAD) |=> input_tap_one == $past(pad_fast))
    else $error("tap one raw source wrong");
  tap_two_src_a: assert property ((tap2_sel == TAP_SEL_MASTER) |=> input_tap_two == $past(in_master))
    else $error("tap two master source wrong");
  pull_select_a: assert property ((state_reg == IOCL_ST_USER) && (pull_sel == PULL_DOWN)
      |=> pull_down_en && !pull_up_en)
    else $error("pull down selection wrong");
  cfg_pullup_a: assert property ((state_reg != IOCL_ST_USER) |=> pull_up_en && !pull_down_en)
    else $error("pin not pulled high during configuration");
  hold_value_a: assert property (s_user_active and !in_edge |=> $stable(in_slave))
    else $error("input flop changed without an edge");
  out_hold_a: assert property (s_user_active and !out_edge |=> $stable(out_slave))
    else $error("output flop changed without an edge");

endmodule

/* iocl_board_model.sv */
module iocl_board_model
  import iocl_pkg::*;
(
  // clock
  input  wire logic pclk,
  // cell pad side
  input  wire logic pad_out,
  input  wire logic pad_oe,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  // board driver
  input  wire logic ext_drive,
  input  wire logic ext_val,
  // level seen by the cell
  output logic      pad_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // an undriven, unpulled pad wanders so a stale level cannot pass for a real one
  logic float_reg;

  always_ff @(posedge pclk) begin
    if (float_reg !== 1'b0) begin
      float_reg <= 1'b0;
    end else begin
      float_reg <= 1'b1;
    end
  end

  always_comb begin
    if (pad_oe) begin
      pad_in = pad_out;
    end else if (ext_drive) begin
      pad_in = ext_val;
    end else if (pull_up_en) begin
      pad_in = 1'b1;
    end else if (pull_down_en) begin
      pad_in = 1'b0;
    end else begin
      pad_in = float_reg;
    end
  end
endmodule

/* tb_programmable_io_cell.sv */
module tb_programmable_io_cell
  import iocl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr, rerr;
  logic        core_out, core_tristate, out_clk, in_clk, global_sr;
  logic        input_tap_one, input_tap_two, pad_in, pad_out, pad_oe;
  logic        pull_up_en, pull_down_en, ext_drive, ext_val;
  int          mismatches, n_tests;

  iocl_top u_iocl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_out(core_out), .core_tristate(core_tristate),
    .out_clk(out_clk), .in_clk(in_clk), .global_sr(global_sr), .input_tap_one(input_tap_one),
    .input_tap_two(input_tap_two), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));

  iocl_board_model u_iocl_board_model (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_drive(ext_drive),
    .ext_val(ext_val), .pad_in(pad_in));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] os, input int oi, ii, oc, ic, ti, dl,
                                      input logic [1:0] t1, t2, pl);
    ctl = 32'h0;
    ctl[CTRL_OUT_SEL_LSB +: 2] = os;
    ctl[CTRL_OUT_INIT]         = 1'(oi);
    ctl[CTRL_IN_INIT]          = 1'(ii);
    ctl[CTRL_OUT_CLK_INV]      = 1'(oc);
    ctl[CTRL_IN_CLK_INV]       = 1'(ic);
    ctl[CTRL_TRI_INV]          = 1'(ti);
    ctl[CTRL_IN_DELAY]         = 1'(dl);
    ctl[CTRL_TAP1_LSB +: 2]    = t1;
    ctl[CTRL_TAP2_LSB +: 2]    = t2;
    ctl[CTRL_PULL_LSB +: 2]    = pl;
  endfunction

  task automatic t_config();
    rd(IOCL_CTRL_OFS);
    chk(rdata, 32'(CTRL_RESET));
    rd(IOCL_CONFIG_OFS);
    chk(rdata, 32'h0);
    rd(8'h0c);
    chk({31'h0, rerr}, 32'h1);
    wr(8'h0c, 32'h1);
    chk({31'h0, rerr}, 32'h1);
    chk({pull_up_en, pull_down_en, pad_oe}, 3'b100);
    wr(IOCL_CTRL_OFS, ctl(OUT_SEL_DIRECT, 1, 1, 0, 0, 0, 1, TAP_SEL_PAD, TAP_SEL_PAD, PULL_DOWN));
    cyc(3);
    chk({pull_up_en, pull_down_en, pad_oe}, 3'b100);
    rd(IOCL_STATUS_OFS);
    chk(rdata[5:3], 3'b111);
    wr(IOCL_STATUS_OFS, 32'hffffffff);
    chk({31'h0, rerr}, 32'h0);
    wr(IOCL_CONFIG_OFS, 32'h1);
    cyc(4);
    rd(IOCL_STATUS_OFS);
    chk(rdata[STAT_USER], 1'b1);
    chk({pull_up_en, pull_down_en}, 2'b01);
  endtask

  task automatic t_pulls();
    for (int c = 0; c < 4; c++) begin
      wr(IOCL_CTRL_OFS, ctl(OUT_SEL_DIRECT, 1, 1, 0, 0, 0, 1, TAP_SEL_PAD, TAP_SEL_PAD, 2'(c)));
      cyc(3);
      chk({pull_up_en, pull_down_en}, {c == 1, c == 2});
    end
  endtask

  task automatic t_out_mux();
    logic [1:0] sel_tab [3];
    sel_tab = '{OUT_SEL_DIRECT, OUT_SEL_INVERT, 2'h3};
    for (int i = 0; i < 3; i++) begin
      wr(IOCL_CTRL_OFS, ctl(sel_tab[i], 1, 1, 0, 0, 0, 1, TAP_SEL_PAD, TAP_SEL_PAD, PULL_NONE));
      for (int v = 0; v < 2; v++) begin
        cyc(1);
        core_out <= 1'(v);
        cyc(3);
        chk(pad_out, 1'(v) ^ (i == 1));
        chk(pad_oe, 1'b1);
      end
    end
    wr(IOCL_CTRL_OFS, ctl(OUT_SEL_FLOP, 1, 1, 0, 0, 0, 1, TAP_SEL_PAD, TAP_SEL_PAD, PULL_NONE));
    cyc(1);
    core_out <= 1'b1;
    cyc(3);
    out_clk <= 1'b1;
    cyc(3);
    core_out <= 1'b0;
    cyc(4);
    chk(pad_out, 1'b1);
    out_clk <= 1'b0;
    cyc(3);
    out_clk <= 1'b1;
    cyc(4);
    chk(pad_out, 1'b0);
  endtask

  // flipping the invert bit alone gives a falling edge, which must not capture
  task automatic t_clk_inv();
    cyc(1);
    core_out <= 1'b1;
    wr(IOCL_CTRL_OFS, ctl(OUT_SEL_FLOP, 1, 1, 1, 0, 0, 1, TAP_SEL_PAD, TAP_SEL_PAD, PULL_NONE));
    cyc(4);
    chk(pad_out, 1'b0);
    out_clk <= 1'b0;
    cyc(4);
    chk(pad_out, 1'b1);
    core_out <= 1'b0;
    cyc(2);
    out_clk <= 1'b1;
    cyc(4);
    chk(pad_out, 1'b1);
  endtask

  task automatic t_tristate();
    for (int t = 0; t < 2; t++) begin
      wr(IOCL_CTRL_OFS, ctl(OUT_SEL_DIRECT, 1, 1, 0, 0, t, 1, TAP_SEL_PAD, TAP_SEL_PAD, PULL_NONE));
      for (int c = 0; c < 2; c++) begin
        cyc(1);
        core_tristate <= 1'(c);
        cyc(3);
        chk(pad_oe, c == t);
      end
    end
  endtask

  task automatic t_input();
    cyc(1);
    ext_drive <= 1'b1;
    ext_val   <= 1'b0;
    wr(IOCL_CTRL_OFS, ctl(OUT_SEL_DIRECT, 1, 1, 0, 0, 0, 0, TAP_SEL_MASTER, TAP_SEL_SLAVE, PULL_NONE));
    cyc(12);
    chk({input_tap_one, input_tap_two}, 2'b01);
    in_clk <= 1'b1;
    cyc(8);
    chk({input_tap_one, input_tap_two}, 2'b00);
    ext_val <= 1'b1;
    cyc(12);
    chk({input_tap_one, input_tap_two}, 2'b00);
    rd(IOCL_STATUS_OFS);
    chk(rdata[STAT_PAD], 1'b1);
    wr(IOCL_CTRL_OFS, ctl(OUT_SEL_DIRECT, 1, 1, 0, 0, 0, 0, TAP_SEL_MASTER, TAP_SEL_PAD, PULL_NONE));
    cyc(4);
    chk(input_tap_two, 1'b1);
    ext_val <= 1'b0;
    cyc(4);
    global_sr <= 1'b1;
    cyc(1);
    global_sr <= 1'b0;
    cyc(3);
    rd(IOCL_STATUS_OFS);
    chk(rdata[5:3], 3'b111);
  endtask

  task automatic t_delay();
    int lat [2];
    int n;
    cyc(1);
    in_clk <= 1'b0;
    for (int d = 0; d < 2; d++) begin
      wr(IOCL_CTRL_OFS, ctl(OUT_SEL_DIRECT, 1, 1, 0, 0, 0, 1 - d, TAP_SEL_MASTER, TAP_SEL_PAD, PULL_NONE));
      cyc(12);
      ext_val <= ~ext_val;
      n = 0;
      do begin
        cyc(1);
        n++;
      end while (input_tap_one !== ext_val && n < 30);
      if (n >= 30) begin
        mismatches++;
        close_out();
      end
      lat[d] = n;
    end
    chk(32'(lat[0] - lat[1]), 32'(DELAY_STAGES));
  endtask

  // raising the invert bit while the input clock sits low makes a rising edge
  task automatic t_in_inv();
    wr(IOCL_CTRL_OFS, ctl(OUT_SEL_DIRECT, 1, 1, 0, 1, 0, 0, TAP_SEL_SLAVE, TAP_SEL_MASTER, PULL_NONE));
    cyc(4);
    chk({input_tap_one, input_tap_two}, 2'b00);
    ext_val <= 1'b1;
    cyc(8);
    chk({input_tap_one, input_tap_two}, 2'b00);
    in_clk <= 1'b1;
    cyc(8);
    chk({input_tap_one, input_tap_two}, 2'b01);
    in_clk <= 1'b0;
    cyc(8);
    chk({input_tap_one, input_tap_two}, 2'b11);
  endtask

  task automatic t_reconfig();
    wr(IOCL_CONFIG_OFS, 32'h0);
    cyc(3);
    chk({pull_up_en, pull_down_en, pad_oe}, 3'b100);
  endtask

  initial begin
    mismatches    = 0;
    n_tests       = 0;
    presetn       = 1'b0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = 8'h00;
    pwdata        = 32'h0;
    pstrb         = 4'hf;
    core_out      = 1'b0;
    core_tristate = 1'b0;
    out_clk       = 1'b0;
    in_clk        = 1'b0;
    global_sr     = 1'b0;
    ext_drive     = 1'b0;
    ext_val       = 1'b0;
    cyc(2);
    presetn <= 1'b1;
    t_config();
    t_pulls();
    t_out_mux();
    t_clk_inv();
    t_tristate();
    t_input();
    t_delay();
    t_in_inv();
    t_reconfig();
    close_out();
  end
endmodule
